// *** logic/cmd_handler.v ***
// common command handler: executes common commands one at a time, written over
// an AXI4-Lite slave, builds text replies into a one-byte output queue.
// assumes acquisition idle and calibration unlock arrive from pins.
// Notes on behaviour
// - macro contents query returns definite block
// - identity reply: maker, model, 0, revision
// - revision digits: two major, two fix
// - macro list quoted names, else one ""
// - learn reply holds only reset-affected settings
// - completion sets event status bit 0
// - completion waits idle when option set
// - no commands run until completion bit
// - completion query queues "1", blocks commands
// - purge removes every macro
// - remove deletes only named macro
// - user data stored only when unlocked
// - user data query always returns block
// - recall restores area 0 to 9
// - recall refused while measurement initiated
// - save stores settings, allowed while initiated
// - power-on fills areas with reset state
// - reset restores settings, aborts, reloads calibration
// - reset spares enables, queue, user data
// - service request mask gates request sources
// - status bits other than bit 6 independent of mask
// - mask clear at power-on, kept by reset
`timescale 1ns/100ps
`include "cch_regs.vh"
module cmd_handler #(
  parameter [31:0] MAKER_TEXT = 32'h4D4B5231, // arbitrary value
  parameter [31:0] MODEL_TEXT = 32'h4D444C31, // arbitrary value
  parameter [7:0] REV_MAJOR = 8'h01,
  parameter [7:0] REV_FIX = 8'h00,
  parameter MSLOT_AW = `CCH_MSLOT_AW,
  parameter MLEN_AW = `CCH_MLEN_AW
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  input wire i_acq_idle,
  input wire i_cal_unlocked,
  input wire [7:0] i_stb_events,
  output wire [7:0] o_stb,
  output wire o_srq,
  output reg [31:0] o_settings,
  output reg o_abort,
  output reg o_cal_reload
);
  localparam SLOTS = 1 << MSLOT_AW;
  localparam [6:0] LMC_END = SLOTS * 4;
  localparam [4:0] MLEN_MAX = 1 << MLEN_AW;
  localparam [7:0] REV_T1 = 8'h30 + REV_MAJOR / 8'h0A;
  localparam [7:0] REV_T0 = 8'h30 + REV_MAJOR % 8'h0A;
  localparam [7:0] REV_F1 = 8'h30 + REV_FIX / 8'h0A;
  localparam [7:0] REV_F0 = 8'h30 + REV_FIX % 8'h0A;
  // 17 characters, first at the top
  localparam [135:0] IDENT = {MAKER_TEXT, `CCH_CH_COMMA, MODEL_TEXT, `CCH_CH_COMMA,
    `CCH_CH_ZERO, `CCH_CH_COMMA, REV_T1, REV_T0, `CCH_CH_DOT, REV_F1, REV_F0};
  localparam [2:0] S_INIT = 3'h0;
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_RCL = 3'h3;
  localparam [2:0] S_RESP = 3'h4;
  localparam [2:0] K_IDN = 3'h0;
  localparam [2:0] K_ONE = 3'h1;
  localparam [2:0] K_NONE = 3'h2;
  localparam [2:0] K_LRN = 3'h3;
  localparam [2:0] K_GMC = 3'h4;
  localparam [2:0] K_PUD = 3'h5;
  localparam [2:0] K_LMC = 3'h6;

  // ===========================================================
  // pin synchronisers
  reg [1:0] acq_sync;
  reg [1:0] cal_sync;
  wire acq_idle = acq_sync[1];
  wire cal_unlocked = cal_sync[1];

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      acq_sync <= 2'b00;
      cal_sync <= 2'b00;
    end
    else
    begin
      acq_sync <= {acq_sync[0], i_acq_idle};
      cal_sync <= {cal_sync[0], i_cal_unlocked};
    end
  end

  // ===========================================================
  // state
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [2:0] state;
  reg [3:0] init_idx;
  reg wait_query;
  reg [3:0] sticky;
  reg ctrl_wait_idle;
  reg esr_opc;
  reg [7:0] sre;
  reg [7:0] outq_byte;
  reg outq_valid;
  reg [2:0] kind;
  reg [6:0] pos;
  reg phase;
  reg emitted_any;
  reg [MSLOT_AW-1:0] resp_slot;
  reg [SLOTS-1:0] mvalid;
  reg [7:0] mname [0:SLOTS-1];
  reg [4:0] mlen [0:SLOTS-1];
  reg [5:0] pud_len;
  integer i;

  wire wr_fire = ~o_awready & ~o_wready & ~o_bvalid;
  wire rd_fire = i_arvalid & o_arready;
  wire pop = rd_fire & (i_araddr == `CCH_ADDR_OUTQ);
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [3:0] op = w_data[3:0];
  wire [7:0] arg = w_data[`CCH_ARG_LSB +: 8];
  wire cmd_fire = wr_fire & (aw_addr == `CCH_ADDR_CMD);
  wire area_ok = arg <= `CCH_AREA_MAX;

  // ===========================================================
  // macro name lookup
  reg hit;
  reg [MSLOT_AW-1:0] hit_slot;

  always @*
  begin
    hit = 1'b0;
    hit_slot = {MSLOT_AW{1'b0}};
    for (i = 0; i < SLOTS; i = i + 1)
      if (mvalid[i] && mname[i] == arg && !hit)
      begin
        hit = 1'b1;
        hit_slot = i[MSLOT_AW-1:0];
      end
  end

  // ===========================================================
  // memories: macro bodies, user data, saved areas
  wire [MSLOT_AW-1:0] md_slot = w_data[`CCH_MD_SLOT_LSB +: MSLOT_AW];
  wire md_start = w_data[`CCH_MD_START];
  wire md_fire = wr_fire & (aw_addr == `CCH_ADDR_MDATA);
  wire m_we = md_fire & (md_start | (mlen[md_slot] < MLEN_MAX));
  wire [MLEN_AW-1:0] m_wofs = md_start ? {MLEN_AW{1'b0}} : mlen[md_slot][MLEN_AW-1:0];
  wire [6:0] didx = pos - 7'h04;
  wire [7:0] m_rdata;
  wire pud_start = w_data[`CCH_PUD_START];
  wire pud_fire = wr_fire & (aw_addr == `CCH_ADDR_PUDDATA);
  wire pud_room = pud_start | (pud_len < `CCH_PUD_MAX);
  wire pud_we = pud_fire & cal_unlocked & pud_room;
  wire [5:0] pud_waddr = pud_start ? 6'h00 : pud_len;
  wire [7:0] p_rdata;
  wire sav_we = (state == S_IDLE) & cmd_fire & (op == `CCH_OP_SAV) & area_ok;
  wire bank_we = (state == S_INIT) | sav_we;
  wire [3:0] bank_waddr = (state == S_INIT) ? init_idx : arg[3:0];
  wire [31:0] bank_wdata = (state == S_INIT) ? `CCH_SETTINGS_RST : o_settings;
  wire [31:0] bank_rdata;

  word_ram #(.W(8), .D(SLOTS << MLEN_AW), .AW(MSLOT_AW + MLEN_AW)) u_macro_ram (
    .i_clk_sys(i_clk_sys),
    .i_we(m_we),
    .i_waddr({md_slot, m_wofs}),
    .i_wdata(w_data[7:0]),
    .i_raddr({resp_slot, didx[MLEN_AW-1:0]}),
    .o_rdata(m_rdata)
  );

  word_ram #(.W(8), .D(64), .AW(`CCH_PUD_AW)) u_pud_ram (
    .i_clk_sys(i_clk_sys),
    .i_we(pud_we),
    .i_waddr(pud_waddr),
    .i_wdata(w_data[7:0]),
    .i_raddr(didx[5:0]),
    .o_rdata(p_rdata)
  );

  word_ram #(.W(32), .D(`CCH_AREAS), .AW(`CCH_AREA_AW)) u_area_ram (
    .i_clk_sys(i_clk_sys),
    .i_we(bank_we),
    .i_waddr(bank_waddr),
    .i_wdata(bank_wdata),
    .i_raddr(arg[3:0]),
    .o_rdata(bank_rdata)
  );

  srq_unit u_srq (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_events(i_stb_events),
    .i_mav(outq_valid),
    .i_esb(esr_opc),
    .i_sre(sre),
    .o_stb(o_stb),
    .o_srq(o_srq)
  );

  // ===========================================================
  // reply character generator
  reg [7:0] rch;
  reg emit;
  reg [6:0] rend;
  reg [6:0] blen;
  reg [6:0] tens;
  reg [135:0] id_sh;
  reg [31:0] set_sh;
  wire [MSLOT_AW-1:0] lslot = pos[MSLOT_AW+1:2];

  always @*
  begin
    emit = 1'b1;
    rch = `CCH_CH_QUOTE;
    id_sh = IDENT << {pos, 3'b000};
    set_sh = o_settings << {pos[1:0], 3'b000};
    case (kind)
      K_LRN: blen = 7'h04;
      K_GMC: blen = {2'b00, mlen[resp_slot]};
      default: blen = {1'b0, pud_len};
    endcase
    tens = blen / 7'h0A;
    rend = blen + 7'h04;
    case (kind)
      K_IDN:
      begin
        rend = 7'h11;
        rch = id_sh[135:128];
      end
      K_ONE:
      begin
        rend = 7'h01;
        rch = `CCH_CH_ONE;
      end
      K_NONE:
        rend = 7'h02;
      K_LMC:
      begin
        rend = LMC_END;
        emit = mvalid[lslot] & ((pos[1:0] != 2'b00) | emitted_any);
        case (pos[1:0])
          2'b00: rch = `CCH_CH_COMMA;
          2'b10: rch = mname[lslot];
          default: rch = `CCH_CH_QUOTE;
        endcase
      end
      default:
      begin
        // definite block, always two length digits
        case (pos)
          7'h00: rch = `CCH_CH_HASH;
          7'h01: rch = `CCH_CH_TWO;
          7'h02: rch = `CCH_CH_ZERO + {1'b0, tens};
          7'h03: rch = `CCH_CH_ZERO + {1'b0, blen - tens * 7'h0A};
          default:
            if (kind == K_LRN)
              rch = set_sh[31:24];
            else if (kind == K_GMC)
              rch = m_rdata;
            else
              rch = p_rdata;
        endcase
      end
    endcase
  end

  // ===========================================================
  // write channel, register updates and command sequencer
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `CCH_RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      state <= S_INIT;
      init_idx <= 4'h0;
      wait_query <= 1'b0;
      sticky <= 4'h0;
      ctrl_wait_idle <= 1'b0;
      esr_opc <= 1'b0;
      sre <= `CCH_SRE_PON;
      outq_byte <= 8'h00;
      outq_valid <= 1'b0;
      kind <= K_IDN;
      pos <= 7'h00;
      phase <= 1'b0;
      emitted_any <= 1'b0;
      resp_slot <= {MSLOT_AW{1'b0}};
      mvalid <= {SLOTS{1'b0}};
      for (i = 0; i < SLOTS; i = i + 1)
      begin
        mname[i] <= 8'h00;
        mlen[i] <= 5'h00;
      end
      pud_len <= 6'h00;
      o_settings <= `CCH_SETTINGS_RST;
      o_abort <= 1'b0;
      o_cal_reload <= 1'b0;
    end
    else
    begin
      o_abort <= 1'b0;
      o_cal_reload <= 1'b0;
      if (i_awvalid && o_awready)
      begin
        aw_addr <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
      if (pop)
        outq_valid <= 1'b0;
      if (wr_fire)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= `CCH_RESP_OKAY;
        case (aw_addr)
          `CCH_ADDR_CMD, `CCH_ADDR_MDATA, `CCH_ADDR_STB, `CCH_ADDR_OUTQ, `CCH_ADDR_PUDLEN:
            o_bresp <= `CCH_RESP_OKAY;
          `CCH_ADDR_STATUS:
            sticky <= sticky & ~w_data[`CCH_ST_STICKY_LSB +: 4];
          `CCH_ADDR_CTRL:
            if (w_strb[0])
              ctrl_wait_idle <= w_data[0];
          `CCH_ADDR_ESR:
            if (w_strb[0])
              esr_opc <= esr_opc & ~w_data[0];
          `CCH_ADDR_SRE:
            if (w_strb[0])
              sre <= w_data[7:0];
          `CCH_ADDR_SETTINGS:
            o_settings <= (o_settings & ~wmask) | (w_data & wmask);
          `CCH_ADDR_PUDDATA:
            if (!cal_unlocked || !pud_room)
              sticky[`CCH_STK_PUD_REF] <= 1'b1;
            else
              pud_len <= pud_start ? 6'h01 : pud_len + 6'h01;
          default:
            o_bresp <= `CCH_RESP_SLVERR;
        endcase
        if (m_we)
        begin
          mvalid[md_slot] <= 1'b1;
          if (md_start)
            mname[md_slot] <= w_data[`CCH_MD_NAME_LSB +: 8];
          mlen[md_slot] <= md_start ? 5'h01 : mlen[md_slot] + 5'h01;
        end
      end
      if (cmd_fire && state != S_IDLE)
        sticky[`CCH_STK_CMD_REF] <= 1'b1;
      case (state)
        S_INIT:
        begin
          // areas take the reset state before any command runs
          init_idx <= init_idx + 4'h1;
          if (init_idx == `CCH_AREA_MAX)
          begin
            init_idx <= 4'h0;
            state <= S_IDLE;
          end
        end
        S_IDLE:
          if (cmd_fire)
          begin
            pos <= 7'h00;
            phase <= 1'b0;
            emitted_any <= 1'b0;
            case (op)
              `CCH_OP_IDN:
              begin
                kind <= K_IDN;
                state <= S_RESP;
              end
              `CCH_OP_LMC:
              begin
                kind <= (|mvalid) ? K_LMC : K_NONE;
                state <= S_RESP;
              end
              `CCH_OP_GMC:
                if (hit)
                begin
                  kind <= K_GMC;
                  resp_slot <= hit_slot;
                  state <= S_RESP;
                end
                else
                  sticky[`CCH_STK_EXEC_ERR] <= 1'b1;
              `CCH_OP_LRN:
              begin
                kind <= K_LRN;
                state <= S_RESP;
              end
              `CCH_OP_OPC, `CCH_OP_OPCQ:
              begin
                wait_query <= (op == `CCH_OP_OPCQ);
                state <= S_WAIT;
              end
              `CCH_OP_PMC:
                mvalid <= {SLOTS{1'b0}};
              `CCH_OP_RMC:
                if (hit)
                  mvalid[hit_slot] <= 1'b0;
                else
                  sticky[`CCH_STK_EXEC_ERR] <= 1'b1;
              `CCH_OP_PUDQ:
              begin
                kind <= K_PUD;
                state <= S_RESP;
              end
              `CCH_OP_RCL:
                if (!area_ok)
                  sticky[`CCH_STK_EXEC_ERR] <= 1'b1;
                else if (!acq_idle)
                  sticky[`CCH_STK_RCL_REJ] <= 1'b1;
                else
                  state <= S_RCL;
              `CCH_OP_SAV:
                if (!area_ok)
                  sticky[`CCH_STK_EXEC_ERR] <= 1'b1;
              `CCH_OP_RST:
              begin
                // enables, queue, user data and macros stay as they are
                o_settings <= `CCH_SETTINGS_RST;
                o_abort <= 1'b1;
                o_cal_reload <= 1'b1;
                state <= S_INIT;
              end
              default:
                sticky[`CCH_STK_EXEC_ERR] <= 1'b1;
            endcase
          end
        S_WAIT:
          // commands run one at a time, so earlier ones are already done
          if (!ctrl_wait_idle || acq_idle)
          begin
            if (wait_query)
            begin
              kind <= K_ONE;
              state <= S_RESP;
            end
            else
            begin
              esr_opc <= 1'b1;
              state <= S_IDLE;
            end
          end
        S_RCL:
        begin
          o_settings <= bank_rdata;
          state <= S_IDLE;
        end
        S_RESP:
          // phase 0 presents the memory address, phase 1 takes the byte
          if (!phase)
          begin
            if (pos == rend)
              state <= S_IDLE;
            else
              phase <= 1'b1;
          end
          else if (!emit)
          begin
            pos <= pos + 7'h01;
            phase <= 1'b0;
          end
          else if (!outq_valid || pop)
          begin
            outq_byte <= rch;
            outq_valid <= 1'b1;
            pos <= pos + 7'h01;
            phase <= 1'b0;
            if (kind == K_LMC && pos[1:0] == 2'b10)
              emitted_any <= 1'b1;
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // ===========================================================
  // read channel; reading the queue register pops it
  reg [31:0] rd_mux;
  reg rd_ok;

  always @*
  begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (i_araddr)
      `CCH_ADDR_CMD, `CCH_ADDR_MDATA, `CCH_ADDR_PUDDATA:
        rd_mux = 32'h00000000;
      `CCH_ADDR_STATUS:
        rd_mux = {20'h00000, sticky, 6'h00, outq_valid, state != S_IDLE};
      `CCH_ADDR_CTRL:
        rd_mux = {31'h00000000, ctrl_wait_idle};
      `CCH_ADDR_ESR:
        rd_mux = {31'h00000000, esr_opc};
      `CCH_ADDR_SRE:
        rd_mux = {24'h000000, sre};
      `CCH_ADDR_STB:
        rd_mux = {24'h000000, o_stb};
      `CCH_ADDR_SETTINGS:
        rd_mux = o_settings;
      `CCH_ADDR_OUTQ:
        rd_mux = {23'h000000, outq_valid, outq_byte};
      `CCH_ADDR_PUDLEN:
        rd_mux = {26'h0000000, pud_len};
      default:
        rd_ok = 1'b0;
    endcase
  end

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `CCH_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_mux;
      o_rresp <= rd_ok ? `CCH_RESP_OKAY : `CCH_RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end
endmodule

// *** logic/cch_regs.vh ***
// register offsets, field positions, reset values and encodings of the
// common command handler; included by the handler and its testbench.
`ifndef CCH_REGS_VH
`define CCH_REGS_VH
// ===========================================================
// byte offsets on the register bus
`define CCH_ADDR_CMD 8'h00
`define CCH_ADDR_STATUS 8'h04
`define CCH_ADDR_CTRL 8'h08
`define CCH_ADDR_ESR 8'h0C
`define CCH_ADDR_SRE 8'h10
`define CCH_ADDR_STB 8'h14
`define CCH_ADDR_SETTINGS 8'h18
`define CCH_ADDR_OUTQ 8'h1C
`define CCH_ADDR_MDATA 8'h20
`define CCH_ADDR_PUDDATA 8'h24
`define CCH_ADDR_PUDLEN 8'h28
// ===========================================================
// command opcodes, CMD[3:0]; argument in CMD[15:8]
`define CCH_OP_IDN 4'h1
`define CCH_OP_LMC 4'h2
`define CCH_OP_GMC 4'h3
`define CCH_OP_LRN 4'h4
`define CCH_OP_OPC 4'h5
`define CCH_OP_OPCQ 4'h6
`define CCH_OP_PMC 4'h7
`define CCH_OP_RMC 4'h8
`define CCH_OP_PUDQ 4'h9
`define CCH_OP_RCL 4'hA
`define CCH_OP_SAV 4'hB
`define CCH_OP_RST 4'hC
// ===========================================================
// field positions
`define CCH_ST_BUSY 0
`define CCH_ST_MAV 1
`define CCH_ST_STICKY_LSB 8
`define CCH_STK_EXEC_ERR 0
`define CCH_STK_RCL_REJ 1
`define CCH_STK_CMD_REF 2
`define CCH_STK_PUD_REF 3
`define CCH_OUTQ_VALID 8
`define CCH_ARG_LSB 8
`define CCH_MD_SLOT_LSB 8
`define CCH_MD_NAME_LSB 16
`define CCH_MD_START 24
`define CCH_PUD_START 8
// ===========================================================
// reset values, sizes and limits
`define CCH_SETTINGS_RST 32'h00000000
`define CCH_SRE_PON 8'h00
`define CCH_AREAS 10
`define CCH_AREA_AW 4
`define CCH_AREA_MAX 8'h09
`define CCH_PUD_AW 6
`define CCH_PUD_MAX 6'h3F
`define CCH_MSLOT_AW 2
`define CCH_MLEN_AW 4
`define CCH_RESP_OKAY 2'h0
`define CCH_RESP_SLVERR 2'h2
// ===========================================================
// reply characters
`define CCH_CH_QUOTE 8'h22
`define CCH_CH_HASH 8'h23
`define CCH_CH_COMMA 8'h2C
`define CCH_CH_DOT 8'h2E
`define CCH_CH_ZERO 8'h30
`define CCH_CH_ONE 8'h31
`define CCH_CH_TWO 8'h32
`define CCH_CH_FOUR 8'h34
`endif

// *** logic/word_ram.v ***
// simple dual-port memory, one write port and one registered read port.
// assumes a single clock; contents are not reset.
`timescale 1ns/100ps
module word_ram #(
  parameter W = 8,
  parameter D = 64,
  parameter AW = 6
) (
  input wire i_clk_sys,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [W-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [W-1:0] o_rdata
);
  reg [W-1:0] mem [0:D-1];

  always @(posedge i_clk_sys)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule

// *** logic/srq_unit.v ***
// status byte assembly and service request generation.
// assumes event inputs come from logic on the same clock.
`timescale 1ns/100ps
module srq_unit (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [7:0] i_events,
  input wire i_mav,
  input wire i_esb,
  input wire [7:0] i_sre,
  output reg [7:0] o_stb,
  output reg o_srq
);
  wire [7:0] raw;
  wire req;

  // bits follow their causes whatever the mask holds
  assign raw = {i_events[7], 1'b0, i_esb, i_mav, i_events[3:0]};
  // bit 6 is the request summary itself, never a source of it
  assign req = |(raw & i_sre & 8'hBF);

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_stb <= 8'h00;
      o_srq <= 1'b0;
    end
    else
    begin
      o_stb <= {raw[7], req, raw[5:0]};
      o_srq <= req;
    end
  end
endmodule

// *** dv/cmd_handler_asserts.sv ***
// port assertions of the command handler
// bound onto cmd_handler; one clock
`timescale 1ns/100ps
module cmd_handler_asserts (
  input wire i_clk_sys,
  input wire i_rst,
  input wire o_awready,
  input wire o_arready,
  input wire o_bvalid,
  input wire i_bready,
  input wire o_rvalid,
  input wire [7:0] i_stb_events,
  input wire [7:0] o_stb,
  input wire o_srq,
  input wire [31:0] o_settings,
  input wire o_abort,
  input wire o_cal_reload
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // ===========================================================
  // bus handshake
  property p_bgap;
    o_bvalid |-> !o_awready;
  endproperty
  a_bgap: assert property (p_bgap) else $error("awready in response");
  property p_rgap;
    o_rvalid |-> !o_arready;
  endproperty
  a_rgap: assert property (p_rgap) else $error("arready in read");
  property p_bone;
    o_bvalid && i_bready |=> !o_bvalid;
  endproperty
  a_bone: assert property (p_bone) else $error("response repeated");
  // ===========================================================
  // status byte and reset
  property p_srq;
    o_srq |-> (o_stb & 8'hBF) != 8'h00;
  endproperty
  a_srq: assert property (p_srq) else $error("request without source");
  property p_ev;
    {o_stb[7], o_stb[3:0]} == $past({i_stb_events[7], i_stb_events[3:0]});
  endproperty
  a_ev: assert property (p_ev) else $error("event bit wrong");
  property p_abort;
    o_abort |=> !o_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not a pulse");
  property p_reload;
    o_abort |-> o_cal_reload;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  property p_set;
    o_abort |-> ##[0:1] (o_settings == 32'h00000000);
  endproperty
  a_set: assert property (p_set) else $error("settings not reset");
endmodule

bind cmd_handler cmd_handler_asserts chk (.*);

// *** dv/host_model.sv ***
// host side: bus master tasks
// assumes calls right after a rising edge
`timescale 1ns/100ps
module host_model (
  input wire i_clk_sys,
  output reg [7:0] o_awaddr = 8'h00,
  output reg o_awvalid = 1'b0,
  input wire i_awready,
  output reg [31:0] o_wdata = 32'h00000000,
  output reg o_wvalid = 1'b0,
  input wire i_wready,
  input wire i_bvalid,
  input wire [1:0] i_bresp,
  output reg [7:0] o_araddr = 8'h00,
  output reg o_arvalid = 1'b0,
  input wire i_arready,
  input wire [31:0] i_rdata,
  input wire i_rvalid
);
  // released lines flip so stale values fail
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    integer n;
    begin
      n = 0;
      {o_awaddr, o_wdata, o_awvalid, o_wvalid} <= {a, d, 2'b11};
      do
      begin
        @(posedge i_clk_sys);
        n++;
        if (o_awvalid && i_awready) {o_awaddr, o_awvalid} <= {~a, 1'b0};
        if (o_wvalid && i_wready) {o_wdata, o_wvalid} <= {~d, 1'b0};
      end while (!i_bvalid && n < 64);
      r = i_bvalid ? i_bresp : 'x;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    integer n;
    begin
      n = 0;
      {o_araddr, o_arvalid} <= {a, 1'b1};
      do
      begin
        @(posedge i_clk_sys);
        n++;
        if (o_arvalid && i_arready) {o_araddr, o_arvalid} <= {~a, 1'b0};
      end while (!i_rvalid && n < 64);
      d = i_rvalid ? i_rdata : 'x;
    end
  endtask
endmodule

// *** dv/tb_common_command_handler.sv ***
// self-checking bench of the command handler
// host_model masters the bus; checker is bound
`timescale 1ns/100ps
`include "cch_regs.vh"
module tb_common_command_handler;
  logic clk = 1'b0, rst = 1'b1, idle = 1'b1, unl = 1'b0;
  logic [7:0] ev = 8'h00;
  wire [7:0] awaddr, araddr, stb;
  wire [31:0] wdata, rdata, settings;
  wire [1:0] bresp;
  wire awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, srq;
  integer fails = 0, check_count = 0;
  logic [1:0] r;
  logic [31:0] v;
  always #5 clk = ~clk;
  cmd_handler dut (.i_clk_sys(clk), .i_rst(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(), .o_rvalid(rvalid), .i_rready(1'b1),
    .i_acq_idle(idle), .i_cal_unlocked(unl), .i_stb_events(ev), .o_stb(stb),
    .o_srq(srq), .o_settings(settings), .o_abort(), .o_cal_reload());
  host_model host (.i_clk_sys(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wvalid(wvalid), .i_wready(wready),
    .i_bvalid(bvalid), .i_bresp(bresp), .o_araddr(araddr), .o_arvalid(arvalid),
    .i_arready(arready), .i_rdata(rdata), .i_rvalid(rvalid));
  // ===========================================================
  // tasks
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
      finish_test;
    end
  endtask
  task finish_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    host.wr(a, d, r);
    chk("bresp", r, `CCH_RESP_OKAY);
  endtask
  task idle_wait;
    integer k;
    k = 0;
    do
    begin
      host.rd(`CCH_ADDR_STATUS, v);
      k++;
    end while (v[0] !== 1'b0 && k < 200);
    chk("busy", v[0], 0);
  endtask
  task sticky(input [3:0] e);
    host.rd(`CCH_ADDR_STATUS, v);
    chk("sticky", v[11:8], e);
    wr(`CCH_ADDR_STATUS, 32'h00000F00);
  endtask
  task rchk(input [7:0] a, input string nm, input [31:0] e);
    host.rd(a, v);
    chk(nm, v, e);
  endtask
  // command, then n reply bytes, first highest in s
  task reply(input [3:0] op, input [7:0] arg, input [135:0] s, input integer n);
    integer i, k;
    wr(`CCH_ADDR_CMD, {16'h0000, arg, 4'h0, op});
    for (i = n - 1; i >= 0; i--)
    begin
      k = 0;
      do
      begin
        host.rd(`CCH_ADDR_OUTQ, v);
        k++;
      end while (!v[8] && k < 50);
      chk("reply", v[8:0], {1'b1, s[8*i+:8]});
    end
    idle_wait;
  endtask
  // ===========================================================
  // sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    idle_wait;
    rchk(`CCH_ADDR_SRE, "sre", 0);
    host.wr(8'h40, 0, r);
    chk("unmapped", r, `CCH_RESP_SLVERR);
    wr(`CCH_ADDR_SRE, 32'h000000A5);
    reply(`CCH_OP_IDN, 0, 136'h4D4B52312C4D444C312C302C30312E3030, 17);
    reply(`CCH_OP_LMC, 0, 16'h2222, 2);
    wr(`CCH_ADDR_MDATA, 32'h01410078);
    wr(`CCH_ADDR_MDATA, 32'h01420179);
    reply(`CCH_OP_LMC, 0, 56'h2241222C224222, 7);
    reply(`CCH_OP_RMC, 8'h41, 0, 0);
    reply(`CCH_OP_LMC, 0, 24'h224222, 3);
    reply(`CCH_OP_GMC, 8'h42, 40'h2332303179, 5);
    reply(`CCH_OP_GMC, 8'h41, 0, 0);
    sticky(4'h1);
    reply(`CCH_OP_PMC, 0, 0, 0);
    reply(`CCH_OP_LMC, 0, 16'h2222, 2);
    wr(`CCH_ADDR_CTRL, 1);
    idle <= 1'b0;
    wr(`CCH_ADDR_CMD, {28'h0, `CCH_OP_OPC});
    repeat (8) @(posedge clk);
    rchk(`CCH_ADDR_ESR, "esr early", 0);
    wr(`CCH_ADDR_CMD, {28'h0, `CCH_OP_IDN});
    sticky(4'h4);
    idle <= 1'b1;
    idle_wait;
    rchk(`CCH_ADDR_ESR, "esr", 1);
    chk("stb5", stb[5], 1);
    wr(`CCH_ADDR_ESR, 1);
    wr(`CCH_ADDR_CTRL, 0);
    reply(`CCH_OP_OPCQ, 0, 8'h31, 1);
    wr(`CCH_ADDR_SETTINGS, 32'h12345678);
    idle <= 1'b0;
    reply(`CCH_OP_SAV, 3, 0, 0);
    reply(`CCH_OP_LRN, 0, 64'h2332303412345678, 8);
    wr(`CCH_ADDR_SETTINGS, 0);
    reply(`CCH_OP_RCL, 3, 0, 0);
    sticky(4'h2);
    chk("settings", settings, 0);
    idle <= 1'b1;
    repeat (4) @(posedge clk);
    reply(`CCH_OP_RCL, 3, 0, 0);
    chk("settings", settings, 32'h12345678);
    reply(`CCH_OP_RCL, 5, 0, 0);
    chk("settings", settings, 0);
    reply(`CCH_OP_RCL, 10, 0, 0);
    sticky(4'h1);
    wr(`CCH_ADDR_PUDDATA, 32'h00000155);
    sticky(4'h8);
    unl <= 1'b1;
    repeat (4) @(posedge clk);
    wr(`CCH_ADDR_PUDDATA, 32'h00000155);
    wr(`CCH_ADDR_PUDDATA, 32'h00000056);
    unl <= 1'b0;
    repeat (4) @(posedge clk);
    reply(`CCH_OP_PUDQ, 0, 48'h233230325556, 6);
    wr(`CCH_ADDR_SETTINGS, 32'h0000ABCD);
    reply(`CCH_OP_RST, 0, 0, 0);
    chk("settings", settings, 0);
    rchk(`CCH_ADDR_SRE, "sre kept", 32'h000000A5);
    rchk(`CCH_ADDR_PUDLEN, "pud kept", 2);
    ev <= 8'h81;
    repeat (3) @(posedge clk);
    chk("srq on", srq, 1);
    ev <= 8'h02;
    repeat (3) @(posedge clk);
    chk("srq off", srq, 0);
    chk("stb1", stb[1], 1);
    finish_test;
  end
endmodule
